// file: rtl/enhanced_timer.sv
// enhanced timer control, counter and register block behind an ahb-lite slave
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.

// ==========================================================
// What this block does
// - pause bit halts counter, timer stays powered
// - pause holds count; resume continues from it
// - clock select picks the counter clock source
// - reserved clock code gives no counter clock
// - run rising edge clears counter, starts counting
// - run falling edge stops, keeps residual count
// - compare mode: run rise restores initial level
// - period field matched against counter bits 9..7
// - period zero: counter overflows, overflow clears
// - channel a mode field selects operating mode
// - compare match applies none, low, high, toggle
// - requested level equal initial: no change
// - pwm mode: inactive, active, pwm, single pulse
// - capture edge: rise, fall, both, disabled
// - output control: initial level or active level
// - polarity bit inverts channel a pin
// - direction flag: 0 up, 1 down, read-only
// - clear select: 0 period/overflow, 1 match a
// - clear select ignored in pwm, pulse, capture
// - overflow or compare match raises request
// - channel b mode uses same mode encoding
// - alignment field selects edge or centre pwm
module enhanced_timer (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // clock sources, one-cycle ticks or pin levels
  input  wire logic        i_high_clock_tick,
  input  wire logic        i_timebase_clock_tick,
  input  wire logic        i_external_clock_pin,
  // channel a pin
  input  wire logic        i_chan_a_pin,
  output logic             o_chan_a_pin,
  output logic             o_chan_a_pin_oe,
  // timer event
  output logic             o_timer_irq_req
);

  // ==========================================================
  // helpers
  function automatic logic [9:0] period_end(input logic [2:0] p);
    period_end = {p, etm_pkg::PERIOD_LOW} - etm_pkg::PERIOD_STEP;
  endfunction : period_end

  // ==========================================================
  // state
  logic [7:0]  ctl0;
  logic [7:0]  ctl1_rw;
  logic [7:0]  ctl2;
  logic [9:0]  cnt;
  logic [9:0]  compare_a_value;
  logic [9:0]  compare_b_value;
  logic        count_direction_flag;
  logic        run_q;
  logic        level;
  logic [1:0]  sys_pre;
  logic [5:0]  high_pre;
  logic        ext_q;
  logic        pin_a_q;
  logic        wr_pend;
  logic [7:0]  wr_addr;

  // ==========================================================
  // field decode
  wire logic           pause_ctl        = ctl0[etm_pkg::PAUSE_BIT];
  wire etm_pkg::clk_sel_t clock_source_sel =
    etm_pkg::clk_sel_t'(ctl0[etm_pkg::CLK_SEL_LSB +: 3]);
  wire logic           run_ctl          = ctl0[etm_pkg::RUN_BIT];
  wire logic [2:0]     period_field     = ctl0[etm_pkg::PERIOD_LSB +: 3];
  wire etm_pkg::mode_t chan_a_mode      =
    etm_pkg::mode_t'(ctl1_rw[etm_pkg::MODE_LSB +: 2]);
  wire etm_pkg::func_t chan_a_output_function =
    etm_pkg::func_t'(ctl1_rw[etm_pkg::FUNC_LSB +: 2]);
  wire logic           chan_a_output_ctl = ctl1_rw[etm_pkg::OC_BIT];
  wire logic           chan_a_polarity  = ctl1_rw[etm_pkg::POL_BIT];
  wire logic           clear_select     = ctl1_rw[etm_pkg::CLR_SEL_BIT];
  wire etm_pkg::mode_t chan_b_mode      =
    etm_pkg::mode_t'(ctl2[etm_pkg::MODE_LSB +: 2]);
  wire etm_pkg::align_t pwm_alignment_sel =
    etm_pkg::align_t'(ctl2[etm_pkg::ALIGN_LSB +: 2]);
  wire logic [7:0]     ctl1 = {ctl1_rw[7:2], count_direction_flag, ctl1_rw[0]};

  // ==========================================================
  // mode decode
  wire logic is_cmp   = chan_a_mode == etm_pkg::MODE_COMPARE;
  wire logic is_cap   = chan_a_mode == etm_pkg::MODE_CAPTURE;
  wire logic is_pwm   = chan_a_mode == etm_pkg::MODE_PWM;
  wire logic is_tmr   = chan_a_mode == etm_pkg::MODE_TIMER;
  wire logic is_pulse = is_pwm && chan_a_output_function == etm_pkg::FUNC_3;
  wire logic centre   = is_pwm && !is_pulse &&
                        pwm_alignment_sel != etm_pkg::ALIGN_EDGE;

  // ==========================================================
  // clock source selection
  wire logic ext_rise = i_external_clock_pin && !ext_q;
  wire logic ext_fall = !i_external_clock_pin && ext_q;
  wire logic high_div16 = i_high_clock_tick &&
                          (high_pre & etm_pkg::DIV16_MASK) == etm_pkg::DIV16_MASK;
  wire logic high_div64 = i_high_clock_tick && high_pre == etm_pkg::DIV64_MASK;
  wire logic sys_div4   = sys_pre == etm_pkg::DIV4_MASK[1:0];
  // reserved code leaves the counter with no clock at all
  wire logic src_tick =
    (clock_source_sel == etm_pkg::CLK_SYS_DIV4)   ? sys_div4 :
    (clock_source_sel == etm_pkg::CLK_SYS)        ? 1'b1 :
    (clock_source_sel == etm_pkg::CLK_HIGH_DIV16) ? high_div16 :
    (clock_source_sel == etm_pkg::CLK_HIGH_DIV64) ? high_div64 :
    (clock_source_sel == etm_pkg::CLK_TIMEBASE)   ? i_timebase_clock_tick :
    (clock_source_sel == etm_pkg::CLK_EXT_RISE)   ? ext_rise :
    (clock_source_sel == etm_pkg::CLK_EXT_FALL)   ? ext_fall :
    1'b0;

  // ==========================================================
  // counter control
  wire logic run_rise = run_ctl && !run_q;
  wire logic advance  = run_ctl && !pause_ctl && src_tick;
  wire logic [9:0] term = period_end(period_field);
  wire logic match_p  = cnt == term;
  wire logic match_a  = cnt == compare_a_value;
  wire logic match_b  = cnt == compare_b_value;
  // clear select only matters in compare and timer modes
  wire logic clr_now =
    (is_cmp || is_tmr) ? (clear_select ? match_a : match_p) :
    is_cap             ? match_p :
    (is_pwm && !centre && !is_pulse) ? match_p : 1'b0;
  wire logic up_now = !centre ? 1'b1 :
                      count_direction_flag ? (cnt == etm_pkg::CNT_RESET) : !match_p;
  wire logic [9:0] step = up_now ? cnt + etm_pkg::CNT_ONE : cnt - etm_pkg::CNT_ONE;
  wire logic [9:0] next_cnt = run_rise ? etm_pkg::CNT_RESET :
                              !advance ? cnt :
                              clr_now  ? etm_pkg::CNT_RESET : step;
  wire logic next_dir = run_rise || !centre ? 1'b0 :
                        advance ? !up_now : count_direction_flag;

  // ==========================================================
  // match events; centre-aligned pwm qualifies match a by direction
  wire logic a_dir_ok = !centre ||
    pwm_alignment_sel == etm_pkg::ALIGN_EITHER ||
    (pwm_alignment_sel == etm_pkg::ALIGN_UP   && !count_direction_flag) ||
    (pwm_alignment_sel == etm_pkg::ALIGN_DOWN &&  count_direction_flag);
  wire logic cap_edge =
    (chan_a_output_function == etm_pkg::FUNC_0) ? ( i_chan_a_pin && !pin_a_q) :
    (chan_a_output_function == etm_pkg::FUNC_1) ? (!i_chan_a_pin &&  pin_a_q) :
    (chan_a_output_function == etm_pkg::FUNC_2) ? (i_chan_a_pin != pin_a_q) :
    1'b0;
  wire logic capture = is_cap && run_ctl && cap_edge;
  wire logic evt_a = advance && match_a && a_dir_ok && !is_cap;
  wire logic event_any = capture || evt_a ||
                         (advance && (match_b || match_p));

  // ==========================================================
  // single pulse: pin edge starts, match a ends by clearing run
  wire logic hw_run_set = is_pulse && ext_rise;
  wire logic hw_run_clr = is_pulse && advance && match_a;

  // ==========================================================
  // channel a output level
  wire logic pwm_active =
    (chan_a_output_function == etm_pkg::FUNC_1) ||
    (chan_a_output_function == etm_pkg::FUNC_2 && cnt < compare_a_value) ||
    (chan_a_output_function == etm_pkg::FUNC_3 && run_ctl);
  wire logic pwm_level = chan_a_output_ctl ? pwm_active : !pwm_active;
  wire logic cmp_level =
    (chan_a_output_function == etm_pkg::FUNC_1) ? 1'b0 :
    (chan_a_output_function == etm_pkg::FUNC_2) ? 1'b1 :
    (chan_a_output_function == etm_pkg::FUNC_3) ? !level : level;
  wire logic next_level =
    is_pwm ? pwm_level :
    (is_cmp && run_rise) ? chan_a_output_ctl :
    (is_cmp && advance && match_a) ? cmp_level : level;
  // output is unused in timer and capture modes, so the pin is released
  wire logic drive_a = is_cmp || is_pwm;

  // ==========================================================
  // ahb-lite decode; zero wait state, always okay
  wire logic addr_ok = i_hsel && i_hready && i_htrans[1];
  wire logic [7:0] rd_addr = i_haddr[7:0];
  wire logic [7:0] rd_byte =
    (rd_addr == etm_pkg::OFS_CTL0)     ? ctl0 :
    (rd_addr == etm_pkg::OFS_CTL1)     ? ctl1 :
    (rd_addr == etm_pkg::OFS_CTL2)     ? ctl2 :
    (rd_addr == etm_pkg::OFS_CNT_LO)   ? cnt[7:0] :
    (rd_addr == etm_pkg::OFS_CNT_HI)   ? {6'h00, cnt[9:8]} :
    (rd_addr == etm_pkg::OFS_CMP_A_LO) ? compare_a_value[7:0] :
    (rd_addr == etm_pkg::OFS_CMP_A_HI) ? {6'h00, compare_a_value[9:8]} :
    (rd_addr == etm_pkg::OFS_CMP_B_LO) ? compare_b_value[7:0] :
    (rd_addr == etm_pkg::OFS_CMP_B_HI) ? {6'h00, compare_b_value[9:8]} :
    8'h00;
  wire logic [7:0] wd = i_hwdata[7:0];
  wire logic wr_c0  = wr_pend && wr_addr == etm_pkg::OFS_CTL0;
  wire logic wr_c1  = wr_pend && wr_addr == etm_pkg::OFS_CTL1;
  wire logic wr_c2  = wr_pend && wr_addr == etm_pkg::OFS_CTL2;
  wire logic wr_alo = wr_pend && wr_addr == etm_pkg::OFS_CMP_A_LO;
  wire logic wr_ahi = wr_pend && wr_addr == etm_pkg::OFS_CMP_A_HI;
  wire logic wr_blo = wr_pend && wr_addr == etm_pkg::OFS_CMP_B_LO;
  wire logic wr_bhi = wr_pend && wr_addr == etm_pkg::OFS_CMP_B_HI;
  // counter words and the direction flag have no write path at all
  wire logic [7:0] next_ctl0 =
    wr_c0 ? wd :
    hw_run_set ? (ctl0 | (8'h01 << etm_pkg::RUN_BIT)) :
    hw_run_clr ? (ctl0 & ~(8'h01 << etm_pkg::RUN_BIT)) : ctl0;
  wire logic [9:0] next_cmp_a =
    capture ? cnt :
    wr_alo  ? {compare_a_value[9:8], wd} :
    wr_ahi  ? {wd[1:0], compare_a_value[7:0]} : compare_a_value;
  wire logic [9:0] next_cmp_b =
    wr_blo ? {compare_b_value[9:8], wd} :
    wr_bhi ? {wd[1:0], compare_b_value[7:0]} : compare_b_value;

  // ==========================================================
  // registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ctl0    <= etm_pkg::CTL_RESET;
      ctl1_rw <= etm_pkg::CTL_RESET;
      ctl2    <= etm_pkg::CTL_RESET;
    end else begin
      ctl0    <= next_ctl0;
      ctl1_rw <= wr_c1 ? wd : ctl1_rw;
      ctl2    <= wr_c2 ? wd : ctl2;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      compare_a_value <= etm_pkg::CNT_RESET;
      compare_b_value <= etm_pkg::CNT_RESET;
    end else begin
      compare_a_value <= next_cmp_a;
      compare_b_value <= next_cmp_b;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cnt                  <= etm_pkg::CNT_RESET;
      count_direction_flag <= 1'b0;
      run_q                <= 1'b0;
      level                <= 1'b0;
    end else begin
      cnt                  <= next_cnt;
      count_direction_flag <= next_dir;
      run_q                <= run_ctl;
      level                <= next_level;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sys_pre  <= 2'b00;
      high_pre <= 6'h00;
      ext_q    <= 1'b0;
      pin_a_q  <= 1'b0;
    end else begin
      sys_pre  <= sys_pre + 2'b01;
      high_pre <= i_high_clock_tick ? high_pre + 6'h01 : high_pre;
      ext_q    <= i_external_clock_pin;
      pin_a_q  <= i_chan_a_pin;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_chan_a_pin    <= 1'b0;
      o_chan_a_pin_oe <= 1'b0;
      o_timer_irq_req <= 1'b0;
    end else begin
      o_chan_a_pin    <= drive_a && (level ^ chan_a_polarity);
      o_chan_a_pin_oe <= drive_a;
      o_timer_irq_req <= event_any;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wr_pend  <= 1'b0;
      wr_addr  <= 8'h00;
      o_hrdata <= 32'h0000_0000;
    end else begin
      wr_pend  <= addr_ok && i_hwrite;
      wr_addr  <= rd_addr;
      o_hrdata <= (addr_ok && !i_hwrite) ? {24'h00_0000, rd_byte} : o_hrdata;
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_run_rise_clear: assert property ($rose(run_ctl) |=> cnt == 10'h000)
    else $error("counter not cleared after run rise");
  a_pause_hold_count: assert property ((pause_ctl && run_q) |=> $stable(cnt))
    else $error("counter moved while paused");
  a_stop_keeps_count: assert property (!run_ctl |=> $stable(cnt))
    else $error("counter moved while off");
  a_reserved_no_clock: assert property ((clock_source_sel == etm_pkg::CLK_RESERVED
    && run_q) |=> $stable(cnt))
    else $error("counter moved with reserved clock");
  a_overflow_clears: assert property ((advance && is_tmr && !clear_select &&
    period_field == 3'b000 && cnt == 10'h3FF) |=> cnt == 10'h000)
    else $error("overflow did not clear counter");
  a_period_match_clear: assert property ((advance && is_cmp && !clear_select &&
    !run_rise && cnt == {period_field, 7'h7F} - 10'h080) |=> cnt == 10'h000)
    else $error("period match did not clear counter");
  a_match_a_clear: assert property ((advance && is_cmp && clear_select &&
    !run_rise && cnt == compare_a_value) |=> cnt == 10'h000)
    else $error("match a did not clear counter");
  a_dir_up_only: assert property (!is_pwm |=> !ctl1[etm_pkg::DIR_BIT])
    else $error("direction flag set outside pwm");
  a_cmp_init_level: assert property ((is_cmp && $rose(run_ctl)) |=> ##1
    o_chan_a_pin == (chan_a_output_ctl ^ chan_a_polarity))
    else $error("pin not at initial level after run rise");
  a_pin_polarity: assert property (is_pwm |=> o_chan_a_pin ==
    ($past(level) ^ $past(chan_a_polarity)))
    else $error("pin polarity wrong");

endmodule : enhanced_timer

// file: rtl/etm_pkg.sv
// constants and types for the enhanced timer register block
package etm_pkg;

  // ==========================================================
  // register offsets, one aligned word each
  localparam logic [7:0] OFS_CTL0     = 8'h00;
  localparam logic [7:0] OFS_CTL1     = 8'h04;
  localparam logic [7:0] OFS_CTL2     = 8'h08;
  localparam logic [7:0] OFS_CNT_LO   = 8'h0C;
  localparam logic [7:0] OFS_CNT_HI   = 8'h10;
  localparam logic [7:0] OFS_CMP_A_LO = 8'h14;
  localparam logic [7:0] OFS_CMP_A_HI = 8'h18;
  localparam logic [7:0] OFS_CMP_B_LO = 8'h1C;
  localparam logic [7:0] OFS_CMP_B_HI = 8'h20;

  // ==========================================================
  // field positions
  localparam int PAUSE_BIT   = 7;
  localparam int CLK_SEL_LSB = 4;
  localparam int RUN_BIT     = 3;
  localparam int PERIOD_LSB  = 0;
  localparam int MODE_LSB    = 6;
  localparam int FUNC_LSB    = 4;
  localparam int OC_BIT      = 3;
  localparam int POL_BIT     = 2;
  localparam int DIR_BIT     = 1;
  localparam int CLR_SEL_BIT = 0;
  localparam int ALIGN_LSB   = 0;

  // ==========================================================
  // reset values and counter constants
  localparam logic [7:0] CTL_RESET   = 8'h00;
  localparam logic [9:0] CNT_RESET   = 10'h000;
  localparam logic [9:0] CNT_ONE     = 10'h001;
  localparam logic [9:0] PERIOD_STEP = 10'h080;
  localparam logic [6:0] PERIOD_LOW  = 7'h7F;
  localparam logic [5:0] DIV4_MASK   = 6'h03;
  localparam logic [5:0] DIV16_MASK  = 6'h0F;
  localparam logic [5:0] DIV64_MASK  = 6'h3F;

  // ==========================================================
  // enumerations
  typedef enum logic [2:0] {
    CLK_SYS_DIV4  = 3'b000,
    CLK_SYS       = 3'b001,
    CLK_HIGH_DIV16 = 3'b010,
    CLK_HIGH_DIV64 = 3'b011,
    CLK_TIMEBASE  = 3'b100,
    CLK_RESERVED  = 3'b101,
    CLK_EXT_RISE  = 3'b110,
    CLK_EXT_FALL  = 3'b111
  } clk_sel_t;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_TIMER   = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    FUNC_0 = 2'b00,
    FUNC_1 = 2'b01,
    FUNC_2 = 2'b10,
    FUNC_3 = 2'b11
  } func_t;

  typedef enum logic [1:0] {
    ALIGN_EDGE   = 2'b00,
    ALIGN_UP     = 2'b01,
    ALIGN_DOWN   = 2'b10,
    ALIGN_EITHER = 2'b11
  } align_t;

endpackage : etm_pkg

// file: verification/enhanced_timer_tb.sv
// self-checking bench for the enhanced timer register block
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end

module enhanced_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic        i_core_clk;
  logic        i_rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        hi_tick;
  logic        tb_tick;
  logic        ext_pin;
  logic        a_pin_in;
  logic        a_pin;
  logic        a_oe;
  logic        irq;
  int          n_fail;
  int          checked;
  int          seed;
  logic [7:0]  q;
  logic [7:0]  v;
  logic [7:0]  b0;
  logic [7:0]  k;
  // delta bounds per clock select over 42 edges
  logic [7:0]  lo [6] = '{8'd10, 8'd42, 8'd2, 8'd0, 8'd42, 8'd0};
  logic [7:0]  hi [6] = '{8'd11, 8'd42, 8'd3, 8'd1, 8'd42, 8'd0};
  // ctl1 value, pin shortly after run rise, pin after match a
  logic [9:0]  tbl [10] = '{{8'h20, 2'b01}, {8'h30, 2'b01}, {8'h10, 2'b00},
                            {8'h18, 2'b10}, {8'h24, 2'b10}, {8'h08, 2'b11},
                            {8'h88, 2'b00}, {8'h98, 2'b11}, {8'hA8, 2'b10},
                            {8'hB8, 2'b10}};

  enhanced_timer uut (
    .i_core_clk            (i_core_clk),
    .i_rst_n               (i_rst_n),
    .i_hsel                (hsel),
    .i_haddr               (haddr),
    .i_htrans              (htrans),
    .i_hwrite              (hwrite),
    .i_hsize               (hsize),
    .i_hready              (hreadyout),
    .i_hwdata              (hwdata),
    .o_hrdata              (hrdata),
    .o_hreadyout           (hreadyout),
    .o_hresp               (hresp),
    .i_high_clock_tick     (hi_tick),
    .i_timebase_clock_tick (tb_tick),
    .i_external_clock_pin  (ext_pin),
    .i_chan_a_pin          (a_pin_in),
    .o_chan_a_pin          (a_pin),
    .o_chan_a_pin_oe       (a_oe),
    .o_timer_irq_req       (irq)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  // ==========================================================
  // tasks
  task complete_run;
    $display("mismatches %0d, comparisons %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : cyc

  // one single word transfer; waits are bounded
  task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do begin @(posedge i_core_clk); n++; end while (hreadyout !== 1'b1 && n < 16);
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    do begin @(posedge i_core_clk); n++; end while (hreadyout !== 1'b1 && n < 32);
    q = hrdata[7:0];
    `CHK(hresp, 1'b0)
    if (hreadyout !== 1'b1) begin
      n_fail++;
      complete_run();
    end
  endtask : bus

  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00);
  endtask : rd

  task bound(input logic [7:0] lim);
    for (int i = 0; i < 12; i++) begin
      cyc($random(seed) & 63);
      rd(etm_pkg::OFS_CNT_LO);
      `CHK(q <= lim, 1'b1)
      rd(etm_pkg::OFS_CNT_HI);
      `CHK(q, 8'h00)
    end
  endtask : bound

  // watchdog against a hung design
  initial begin
    cyc(60000);
    n_fail++;
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 15291;
    n_fail = 0;
    checked = 0;
    i_rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; hi_tick = 1'b0; tb_tick = 1'b0;
    ext_pin = 1'b0; a_pin_in = 1'b0;
    cyc(8);
    i_rst_n <= 1'b1;
    cyc(1);
    rd(etm_pkg::OFS_CTL0);
    `CHK(q, 8'h00)
    rd(etm_pkg::OFS_CTL1);
    `CHK(q, 8'h00)
    v = $random(seed);
    wr(etm_pkg::OFS_CTL2, v);
    rd(etm_pkg::OFS_CTL2);
    `CHK(q, v)
    wr(etm_pkg::OFS_CTL2, 8'h00);
    wr(etm_pkg::OFS_CMP_B_HI, v);
    rd(etm_pkg::OFS_CMP_B_HI);
    `CHK(q, v & 8'h03)
    wr(8'h24, v);
    rd(8'h24);
    `CHK(q, 8'h00)
    v = ($random(seed) & 8'h3D) | 8'hC2;
    wr(etm_pkg::OFS_CTL1, v);
    rd(etm_pkg::OFS_CTL1);
    `CHK(q, v & 8'hFD)
    for (int m = 0; m < 4; m++) begin
      wr(etm_pkg::OFS_CTL1, 8'(m << 6));
      cyc(3);
      `CHK(a_oe, (m == 0 || m == 2))
    end
    // clock sources, timer mode left selected
    tb_tick <= 1'b1;
    hi_tick <= 1'b1;
    for (int s = 0; s < 6; s++) begin
      wr(etm_pkg::OFS_CTL0, {1'b0, 3'(s), 4'h8});
      rd(etm_pkg::OFS_CNT_LO);
      b0 = q;
      cyc(40);
      rd(etm_pkg::OFS_CNT_LO);
      v = q - b0;
      `CHK(v >= lo[s] && v <= hi[s], 1'b1)
    end
    for (int e = 0; e < 2; e++) begin
      wr(etm_pkg::OFS_CTL0, {2'b01, 1'b1, 1'(e), 4'h8});
      rd(etm_pkg::OFS_CNT_LO);
      b0 = q;
      k = 8'(1 + ($random(seed) & 7));
      for (int i = 0; i < k; i++) begin
        ext_pin <= 1'b1;
        cyc(3);
        ext_pin <= 1'b0;
        cyc(3);
      end
      cyc(3);
      rd(etm_pkg::OFS_CNT_LO);
      `CHK(8'(q - b0), k)
    end
    // pause, run fall and run rise
    wr(etm_pkg::OFS_CTL0, 8'h18);
    cyc(150);
    wr(etm_pkg::OFS_CTL0, 8'h98);
    rd(etm_pkg::OFS_CNT_LO);
    b0 = q;
    cyc(20);
    rd(etm_pkg::OFS_CNT_LO);
    `CHK(q, b0)
    wr(etm_pkg::OFS_CNT_LO, $random(seed));
    rd(etm_pkg::OFS_CNT_LO);
    `CHK(q, b0)
    wr(etm_pkg::OFS_CTL0, 8'h18);
    cyc(20);
    rd(etm_pkg::OFS_CNT_LO);
    `CHK(8'(q - b0) inside {[8'd10:8'd40]}, 1'b1)
    wr(etm_pkg::OFS_CTL0, 8'h10);
    rd(etm_pkg::OFS_CNT_LO);
    b0 = q;
    cyc(20);
    rd(etm_pkg::OFS_CNT_LO);
    `CHK(q, b0)
    wr(etm_pkg::OFS_CTL0, 8'h18);
    // the clear lands one edge after the run bit, so let it settle first
    cyc(1);
    rd(etm_pkg::OFS_CNT_LO);
    `CHK(q < 8'd8, 1'b1)
    // period clear, then match a clear
    wr(etm_pkg::OFS_CTL0, 8'h11);
    wr(etm_pkg::OFS_CTL0, 8'h19);
    bound(8'd127);
    // period match every 128 clocks must pulse the request; sampled off the edge
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(negedge i_core_clk);
    `CHK(irq, 1'b1)
    @(posedge i_core_clk);
    wr(etm_pkg::OFS_CTL0, 8'h10);
    wr(etm_pkg::OFS_CMP_A_LO, 8'd50);
    wr(etm_pkg::OFS_CMP_A_HI, 8'h00);
    wr(etm_pkg::OFS_CTL1, 8'hC1);
    wr(etm_pkg::OFS_CTL0, 8'h18);
    bound(8'd50);
    // compare and pwm pin behaviour, mode changed only while off
    wr(etm_pkg::OFS_CMP_A_LO, 8'd20);
    for (int t = 0; t < 10; t++) begin
      wr(etm_pkg::OFS_CTL0, 8'h11);
      wr(etm_pkg::OFS_CTL1, tbl[t][9:2]);
      wr(etm_pkg::OFS_CTL0, 8'h19);
      cyc(4);
      `CHK(a_pin, tbl[t][1])
      cyc(30);
      `CHK(a_pin, tbl[t][0])
    end
    // capture edge codes
    for (int f = 0; f < 4; f++) begin
      wr(etm_pkg::OFS_CTL0, 8'h10);
      wr(etm_pkg::OFS_CTL1, 8'(8'h40 | (f << 4)));
      wr(etm_pkg::OFS_CMP_A_LO, 8'hFF);
      wr(etm_pkg::OFS_CTL0, 8'h18);
      cyc(30);
      a_pin_in <= 1'b1;
      cyc(10);
      a_pin_in <= 1'b0;
      cyc(5);
      rd(etm_pkg::OFS_CMP_A_LO);
      `CHK(q !== 8'hFF, f != 3)
    end
    complete_run();
  end

endmodule : enhanced_timer_tb
